/* verilog/sensor_defs.svh */
// Purpose: offsets, field positions, reset values of the sensor status/config bank
// Assumes: 8-bit register pointer and 8-bit data on the register port
// Notes:   definitions only
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH
`define SENS_ADDR_STATUS  8'h04
`define SENS_ADDR_CONFIG  8'h05
`define SENS_BURST_BIT    7
`define SENS_UPDATE_BIT   6
`define SENS_RANGE_BIT    4
`define SENS_TYPE_MSB     6
`define SENS_TYPE_LSB     4
`define SENS_COEF_MSB     2
`define SENS_COEF_LSB     0
`define SENS_RESET_VALUE  8'h00
`define SENS_READ_UNMAPPED 8'h00
`endif

/* verilog/sensor_pkg.sv */
// Purpose: types shared by the sensor status/config bank and its filter
// Assumes: nothing
// Notes:   constants live in sensor_defs.svh
package sensor_pkg;
  typedef enum logic [2:0] {
    TC_K = 3'b000,
    TC_J = 3'b001,
    TC_T = 3'b010,
    TC_N = 3'b011,
    TC_S = 3'b100,
    TC_E = 3'b101,
    TC_B = 3'b110,
    TC_R = 3'b111
  } tc_kind_type;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_DIV  = 2'b01,
    F_DONE = 2'b10
  } filt_state_type;
endpackage

/* verilog/filter_if.sv */
// Purpose: request/answer bundle between the bank and its averaging engine
// Assumes: one clock
// Notes:   start and flush are one-cycle pulses
`timescale 1ns/100ps
interface filter_if #(parameter int W = 16);
  logic                start;
  logic                flush;
  logic signed [W-1:0] sample;
  logic [2:0]          coeff;
  logic                done;
  logic signed [W-1:0] result;
  modport ctrl   (output start, flush, sample, coeff, input done, result);
  modport engine (input start, flush, sample, coeff, output done, result);
endinterface

/* verilog/exponential_average_filter.sv */
// Purpose: first-order recursive average y = (2x + (2^n-1)y) / (2^n+1)
// Assumes: a new start only after done or flush
// Notes:   serial restoring divider, one quotient bit per cycle, truncates toward zero
`timescale 1ns/100ps
module exponential_average_filter #(
  parameter int W = 16
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  filter_if.engine  fi
);
  localparam int NW      = W + 9;
  localparam int DIV_LAT = NW + 2;

  sensor_pkg::filt_state_type state;
  logic                 have_hist;
  logic signed [W-1:0]  y_prev;
  logic [NW-1:0]        quo;
  logic [7:0]           rem;
  logic [7:0]           den;
  logic [7:0]           den_q;
  logic [5:0]           count;
  logic                 neg;
  logic signed [NW-1:0] num;
  logic [NW-1:0]        mag;
  logic [8:0]           trial;

  always_comb begin
    den   = (8'h01 << fi.coeff) + 8'h01;
    num   = ({{(NW-W){fi.sample[W-1]}}, fi.sample} <<< 1)
          + {{(NW-W){y_prev[W-1]}}, y_prev} * $signed({{(NW-8){1'b0}}, den - 8'h02});
    mag   = num[NW-1] ? -num : num;
    trial = {rem, quo[NW-1]};
  end

  always_ff @(posedge clk_sys) begin
    if (srst || fi.flush) begin
      state     <= sensor_pkg::F_IDLE;
      have_hist <= 1'b0;
      fi.done   <= 1'b0;
      rem       <= 8'h00;
      quo       <= '0;
      count     <= 6'h00;
      neg       <= 1'b0;
      den_q     <= 8'h00;
    end else begin
      fi.done <= 1'b0;
      case (state)
        sensor_pkg::F_IDLE: begin
          if (fi.start) begin
            have_hist <= 1'b1;
            if (fi.coeff == 3'h0 || !have_hist) begin
              fi.done <= 1'b1;
            end else begin
              quo   <= mag;
              neg   <= num[NW-1];
              rem   <= 8'h00;
              den_q <= den;
              count <= 6'(NW - 1);
              state <= sensor_pkg::F_DIV;
            end
          end
        end
        sensor_pkg::F_DIV: begin
          if (trial >= {1'b0, den_q}) begin
            rem <= 8'(trial - {1'b0, den_q});
            quo <= {quo[NW-2:0], 1'b1};
          end else begin
            rem <= trial[7:0];
            quo <= {quo[NW-2:0], 1'b0};
          end
          if (count == 6'h00) begin
            state <= sensor_pkg::F_DONE;
          end else begin
            count <= count - 6'h01;
          end
        end
        sensor_pkg::F_DONE: begin
          fi.done <= 1'b1;
          state   <= sensor_pkg::F_IDLE;
        end
        default: state <= sensor_pkg::F_IDLE;
      endcase
    end
  end

  // history survives a flush only in y_prev; have_hist decides whether it is used
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fi.result <= '0;
      y_prev    <= '0;
    end else if (!fi.flush && state == sensor_pkg::F_IDLE && fi.start
                 && (fi.coeff == 3'h0 || !have_hist)) begin
      fi.result <= fi.sample;
      y_prev    <= fi.sample;
    end else if (!fi.flush && state == sensor_pkg::F_DONE) begin
      fi.result <= neg ? -quo[W-1:0] : quo[W-1:0];
      y_prev    <= neg ? -quo[W-1:0] : quo[W-1:0];
    end
  end

  sequence s_div_start;
    fi.start && state == sensor_pkg::F_IDLE && have_hist && fi.coeff != 3'h0;
  endsequence
  property p_div_latency;
    @(posedge clk_sys) disable iff (srst || fi.flush)
      s_div_start |-> ##DIV_LAT fi.done;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("filter divide latency wrong");
  property p_bypass;
    @(posedge clk_sys) disable iff (srst)
      (fi.start && !fi.flush && state == sensor_pkg::F_IDLE && fi.coeff == 3'h0)
      |=> fi.done && fi.result == $past(fi.sample);
  endproperty
  a_bypass: assert property (p_bypass) else $error("unfiltered pass-through wrong");
endmodule

/* verilog/sensor_status_and_filter_config.sv */
// Purpose: status flags, thermocouple type select and averaging filter control
// Assumes: register port and conversion strobes synchronous to clk_sys
// Notes:   read data is registered, one cycle behind the pointer
`timescale 1ns/100ps
`include "sensor_defs.svh"
module sensor_status_and_filter_config #(
  parameter int W = 16
) (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    conv_valid,
  input  wire logic signed [W-1:0]     raw_hot,
  input  wire logic signed [W-1:0]     comp_hot,
  input  wire logic signed [W-1:0]     cold_in,
  input  wire logic                    thermocouple_input_voltage_over,
  input  wire logic                    hot_over_range,
  input  wire logic                    burst_done,
  input  wire logic [3:0][W-1:0]       alert_limit,
  input  wire logic [3:0]              alert_src_cold,
  output logic signed [W-1:0]          delta_temp,
  output logic signed [W-1:0]          hot_temp,
  output logic signed [W-1:0]          cold_temp,
  output sensor_pkg::tc_kind_type      tc_type,
  output logic [7:0]                   coeff_sel,
  output logic [2:0]                   filter_coeff
);
  filter_if #(.W(W)) fi ();

  logic       burst_flag;
  logic       update_flag;
  logic       range_flag;
  logic [3:0] alert_status;
  logic       filt_busy;
  logic       range_now;
  logic       wr_status;
  logic       wr_config;
  logic       accept;
  logic [3:0] next_alert;
  logic signed [W-1:0] hot_src;

  always_comb begin
    wr_status = reg_wr && reg_addr == `SENS_ADDR_STATUS;
    wr_config = reg_wr && reg_addr == `SENS_ADDR_CONFIG;
    range_now = thermocouple_input_voltage_over || hot_over_range;
    accept    = conv_valid && !range_now && !filt_busy && !wr_config;
  end

  // filter request: raw sample in, flush on every configuration write
  always_comb begin
    fi.start  = accept;
    fi.sample = raw_hot;
    fi.coeff  = filter_coeff;
    fi.flush  = wr_config;
  end

  exponential_average_filter #(.W(W)) u_filter (
    .clk_sys (clk_sys),
    .srst    (srst),
    .fi      (fi)
  );

  always_ff @(posedge clk_sys) begin
    if (srst || wr_config) begin
      filt_busy <= 1'b0;
    end else if (accept) begin
      filt_busy <= 1'b1;
    end else if (fi.done) begin
      filt_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hot_temp  <= '0;
      cold_temp <= '0;
    end else if (accept) begin
      hot_temp  <= comp_hot;
      cold_temp <= cold_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      delta_temp <= '0;
    end else if (fi.done && !wr_config) begin
      delta_temp <= fi.result;
    end
  end

  // clears are write-zero; a set arriving in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      burst_flag  <= 1'b0;
      update_flag <= 1'b0;
    end else begin
      burst_flag  <= burst_done
                  || (burst_flag && !(wr_status && !reg_wdata[`SENS_BURST_BIT]));
      update_flag <= (fi.done && !wr_config)
                  || (update_flag && !(wr_status && !reg_wdata[`SENS_UPDATE_BIT]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      range_flag <= 1'b0;
    end else begin
      range_flag <= range_now;
    end
  end

  // filtered data feeds the hot-junction alert source when filtering is on
  always_comb begin
    hot_src = (filter_coeff != 3'h0) ? delta_temp : hot_temp;
    for (int i = 0; i < 4; i++) begin
      next_alert[i] = $signed(alert_src_cold[i] ? cold_temp : hot_src)
                    > $signed(alert_limit[i]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alert_status <= 4'h0;
    end else begin
      alert_status <= next_alert;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tc_type      <= sensor_pkg::TC_K;
      filter_coeff <= 3'h0;
    end else if (wr_config) begin
      tc_type      <= sensor_pkg::tc_kind_type'(reg_wdata[`SENS_TYPE_MSB:`SENS_TYPE_LSB]);
      filter_coeff <= reg_wdata[`SENS_COEF_MSB:`SENS_COEF_LSB];
    end
  end

  // one-hot pick of the correction table; lags tc_type by a cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      coeff_sel <= 8'h01;
    end else begin
      coeff_sel <= 8'h01 << tc_type;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= `SENS_RESET_VALUE;
    end else begin
      case (reg_addr)
        `SENS_ADDR_STATUS: reg_rdata <= {burst_flag, update_flag, 1'b0, range_flag, alert_status};
        `SENS_ADDR_CONFIG: reg_rdata <= {1'b0, tc_type, 1'b0, filter_coeff};
        default:           reg_rdata <= `SENS_READ_UNMAPPED;
      endcase
    end
  end

  property p_burst_set;
    @(posedge clk_sys) disable iff (srst) burst_done |=> burst_flag;
  endproperty
  a_burst_set: assert property (p_burst_set) else $error("burst flag not set");
  sequence s_status_clear;
    wr_status && !reg_wdata[`SENS_UPDATE_BIT] && !fi.done;
  endsequence
  property p_update_clear;
    @(posedge clk_sys) disable iff (srst) s_status_clear |=> !update_flag;
  endproperty
  a_update_clear: assert property (p_update_clear) else $error("update flag not cleared");
  property p_update_set;
    @(posedge clk_sys) disable iff (srst)
      (fi.done && !wr_config) |=> update_flag && delta_temp == $past(fi.result);
  endproperty
  a_update_set: assert property (p_update_set) else $error("update flag or delta missing");
  property p_range;
    @(posedge clk_sys) disable iff (srst)
      ##1 range_flag == $past(thermocouple_input_voltage_over || hot_over_range);
  endproperty
  a_range: assert property (p_range) else $error("range flag wrong");
  property p_skip;
    @(posedge clk_sys) disable iff (srst)
      (conv_valid && range_now && !filt_busy)
      |=> $stable(hot_temp) && $stable(cold_temp) && !fi.done;
  endproperty
  a_skip: assert property (p_skip) else $error("conversion not skipped");
  property p_alert0;
    @(posedge clk_sys) disable iff (srst)
      ##1 alert_status[0] == ($past($signed(alert_src_cold[0] ? cold_temp : hot_src))
                              > $past($signed(alert_limit[0])));
  endproperty
  a_alert0: assert property (p_alert0) else $error("alert 1 status wrong");
  property p_type;
    @(posedge clk_sys) disable iff (srst)
      wr_config |=> tc_type == $past(reg_wdata[6:4]) ##1 coeff_sel == (8'h01 << $past(tc_type));
  endproperty
  a_type: assert property (p_type) else $error("type decode or table select wrong");
  property p_sel_onehot;
    @(posedge clk_sys) disable iff (srst) $onehot(coeff_sel);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("coefficient select not one-hot");
  sequence s_cfg_write;
    wr_config ##1 !wr_config;
  endsequence
  property p_flush;
    @(posedge clk_sys) disable iff (srst) s_cfg_write |-> !filt_busy && !fi.done;
  endproperty
  a_flush: assert property (p_flush) else $error("filter not reset by config write");
  property p_set_wins;
    @(posedge clk_sys) disable iff (srst)
      (burst_done && wr_status && !reg_wdata[`SENS_BURST_BIT]) |=> burst_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
endmodule

/* verif/host_model.sv */
// Purpose: register-port host that writes and reads single bytes
// Assumes: every task is entered at a falling edge of clk_sys
// Notes:   released write data is inverted so a stale byte is never reused
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk_sys,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // read data is registered, so it is taken one cycle after the pointer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

/* verif/tb_sensor_status_and_filter_config.sv */
// Purpose: self-checking bench of the status/config bank
// Assumes: inputs change at the falling edge of clk_sys
// Notes:   filtering waits use the fixed latency of the serial divider
`timescale 1ns/100ps
`include "sensor_defs.svh"
module tb_sensor_status_and_filter_config;
  logic                clk_sys;
  logic                srst;
  logic [7:0]          reg_addr;
  logic                reg_wr;
  logic [7:0]          reg_wdata;
  logic [7:0]          reg_rdata;
  logic                conv_valid;
  logic signed [15:0]  raw_hot;
  logic signed [15:0]  comp_hot;
  logic signed [15:0]  cold_in;
  logic                volt_over;
  logic                hot_over;
  logic                burst_done;
  logic [3:0][15:0]    alert_limit;
  logic [3:0]          alert_src_cold;
  logic signed [15:0]  delta_temp;
  logic signed [15:0]  hot_temp;
  logic signed [15:0]  cold_temp;
  sensor_pkg::tc_kind_type tc_type;
  logic [7:0]          coeff_sel;
  logic [2:0]          filter_coeff;
  int                  miscompares;
  int                  comparisons;
  logic [7:0]          d;

  sensor_status_and_filter_config #(.W(16)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .raw_hot(raw_hot), .comp_hot(comp_hot), .cold_in(cold_in),
    .thermocouple_input_voltage_over(volt_over), .hot_over_range(hot_over),
    .burst_done(burst_done), .alert_limit(alert_limit),
    .alert_src_cold(alert_src_cold), .delta_temp(delta_temp), .hot_temp(hot_temp),
    .cold_temp(cold_temp), .tc_type(tc_type), .coeff_sel(coeff_sel),
    .filter_coeff(filter_coeff)
  );

  host_model u_host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic conv(input logic [15:0] r, input logic [15:0] c, input logic [15:0] j);
    conv_valid = 1'b1;
    raw_hot = r;
    comp_hot = c;
    cold_in = j;
    @(negedge clk_sys);
    conv_valid = 1'b0;
    raw_hot = ~r;
    comp_hot = ~c;
    cold_in = ~j;
  endtask

  task automatic sc_reset_and_unmapped;
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("status reset", 16'h0000, {8'h00, d});
    u_host.rd(`SENS_ADDR_CONFIG, d);
    chk("config reset", 16'h0000, {8'h00, d});
    chk("table select reset", 16'h0001, {8'h00, coeff_sel});
    u_host.wr(8'h3F, 8'h77);
    u_host.rd(8'h3F, d);
    chk("unmapped read", 16'h0000, {8'h00, d});
    u_host.rd(`SENS_ADDR_CONFIG, d);
    chk("config untouched", 16'h0000, {8'h00, d});
  endtask

  task automatic sc_types_and_coeffs;
    for (int t = 0; t < 8; t++) begin
      u_host.wr(`SENS_ADDR_CONFIG, {1'b1, t[2:0], 1'b1, 3'(7 - t)});
      u_host.rd(`SENS_ADDR_CONFIG, d);
      chk("config readback", {8'h00, 1'b0, t[2:0], 1'b0, 3'(7 - t)}, {8'h00, d});
      chk("type", 16'(t), {13'h0000, tc_type});
      chk("coefficient n", 16'(7 - t), {13'h0000, filter_coeff});
      chk("table select", 16'h0001 << t, {8'h00, coeff_sel});
    end
  endtask

  task automatic sc_bypass_and_update_flag;
    u_host.wr(`SENS_ADDR_CONFIG, 8'h10);
    conv(16'h0064, 16'h0190, 16'h0014);
    repeat (3) @(negedge clk_sys);
    chk("delta bypass", 16'h0064, delta_temp);
    chk("hot", 16'h0190, hot_temp);
    chk("cold", 16'h0014, cold_temp);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("update set", 16'h0001, {15'h0000, d[6]});
    u_host.wr(`SENS_ADDR_STATUS, 8'hC0);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("update on write one", 16'h0001, {15'h0000, d[6]});
    u_host.wr(`SENS_ADDR_STATUS, 8'h00);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("update cleared", 16'h0000, {15'h0000, d[6]});
  endtask

  task automatic sc_filter_and_flush;
    u_host.wr(`SENS_ADDR_CONFIG, 8'h01);
    conv(16'h0000, 16'h0000, 16'h0000);
    repeat (4) @(negedge clk_sys);
    conv(16'h012C, 16'h0000, 16'h0000);
    repeat (30) @(negedge clk_sys);
    // n=1: k=2/3, so (2*300 + 1*0)/3
    chk("filtered delta", 16'h00C8, delta_temp);
    // compensated hot value is 0 against zero limits, so only the filtered 200 can trip them
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("alert on filtered", 16'h000F, {12'h000, d[3:0]});
    u_host.wr(`SENS_ADDR_CONFIG, 8'h01);
    conv(16'h005A, 16'h0000, 16'h0000);
    repeat (3) @(negedge clk_sys);
    chk("delta after flush", 16'h005A, delta_temp);
  endtask

  task automatic sc_range;
    u_host.wr(`SENS_ADDR_CONFIG, 8'h00);
    conv(16'h0032, 16'h0190, 16'h0014);
    repeat (3) @(negedge clk_sys);
    volt_over = 1'b1;
    u_host.wr(`SENS_ADDR_STATUS, 8'h00);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("range voltage", 16'h0001, {15'h0000, d[4]});
    conv(16'h0111, 16'h0222, 16'h0033);
    repeat (3) @(negedge clk_sys);
    chk("hot held", 16'h0190, hot_temp);
    chk("delta held", 16'h0032, delta_temp);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("no update", 16'h0000, {15'h0000, d[6]});
    // the range bit is registered, so let one edge pass before each read
    volt_over = 1'b0;
    @(negedge clk_sys);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("range clear", 16'h0000, {15'h0000, d[4]});
    hot_over = 1'b1;
    @(negedge clk_sys);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("range result", 16'h0001, {15'h0000, d[4]});
    hot_over = 1'b0;
    @(negedge clk_sys);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("range released", 16'h0000, {15'h0000, d[4]});
  endtask

  task automatic sc_alerts;
    // hot source is 400, cold source is 20; equal limits must not trip
    alert_src_cold = 4'b1100;
    alert_limit[0] = 16'h0190;
    alert_limit[1] = 16'h018F;
    alert_limit[2] = 16'h0013;
    alert_limit[3] = 16'h0014;
    repeat (2) @(negedge clk_sys);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("alert bits", 16'h0006, {12'h000, d[3:0]});
    alert_limit[0] = 16'hFFF0;
    alert_limit[3] = 16'hFFFF;
    repeat (2) @(negedge clk_sys);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("alert signed", 16'h000F, {12'h000, d[3:0]});
  endtask

  task automatic sc_burst;
    burst_done = 1'b1;
    @(negedge clk_sys);
    burst_done = 1'b0;
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("burst set", 16'h0001, {15'h0000, d[7]});
    burst_done = 1'b1;
    u_host.wr(`SENS_ADDR_STATUS, 8'h00);
    burst_done = 1'b0;
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("set beats clear", 16'h0001, {15'h0000, d[7]});
    u_host.wr(`SENS_ADDR_STATUS, 8'h00);
    u_host.rd(`SENS_ADDR_STATUS, d);
    chk("burst cleared", 16'h0000, {15'h0000, d[7]});
  endtask

  initial begin
    miscompares = 0;
    comparisons = 0;
    srst = 1'b1;
    conv_valid = 1'b0;
    raw_hot = 16'h0000;
    comp_hot = 16'h0000;
    cold_in = 16'h0000;
    volt_over = 1'b0;
    hot_over = 1'b0;
    burst_done = 1'b0;
    alert_limit = '0;
    alert_src_cold = 4'h0;
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    sc_reset_and_unmapped();
    sc_types_and_coeffs();
    sc_bypass_and_update_flag();
    sc_filter_and_flush();
    sc_range();
    sc_alerts();
    sc_burst();
    results();
  end

  // a hang is cut short here and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    results();
  end
endmodule
